// ### logic/host_bus_pkg.sv
// Constants shared by the host parallel bus port and its testbench
package host_bus_pkg;
    // Bus profile codes, fixed by static configuration
    localparam logic [2:0] PROF_MUX_BASIC = 3'h0;
    localparam logic [2:0] PROF_MUX_EXT_ADDR = 3'h1;
    localparam logic [2:0] PROF_SINGLE_READ = 3'h2;
    localparam logic [2:0] PROF_RW_LEVEL = 3'h3;
    localparam logic [2:0] PROF_RW_LEVEL_BUS_EN = 3'h4;
    localparam logic [2:0] PROF_NO_STROBE = 3'h5;
    localparam logic [2:0] PROF_DATA_STROBE = 3'h6;
    localparam logic [2:0] PROF_RESET = PROF_MUX_BASIC;
    // Where the latched address is presented
    localparam logic [1:0] LATCH_OUT_NONE = 2'h0;
    localparam logic [1:0] LATCH_OUT_FIRST = 2'h1;
    localparam logic [1:0] LATCH_OUT_SECOND = 2'h2;
    // Widths
    localparam int DATA_W = 8;
    localparam int SHARED_W = 16;
    localparam int UPPER_W = 8;
    localparam int FULL_W = 24;
    localparam int EXT_LOW_W = 4;
    localparam int EXT_UPPER_W = 4;
    localparam int SYNC_STAGES = 2;
    // Synchronised pin vector: 5 control pins, address/data, first port, upper address
    localparam int CTL_PINS = 5;
    localparam int SYNC_W = CTL_PINS + SHARED_W + DATA_W + UPPER_W;
    localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;
    localparam logic [SHARED_W-1:0] SHARED_RESET = 16'h0000;
    localparam logic [FULL_W-1:0] ADDR_RESET = 24'h000000;
endpackage

// ### logic/host_bus_port.sv
// Host parallel bus port: profile decode, address latch, access sequencing
`timescale 1ns/1ps
module host_bus_port
    import host_bus_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic [2:0] profile_i,
    input wire logic nonmux_i,
    input wire logic [1:0] latch_out_cfg_i,
    input wire logic bus_control_input_first_i,
    input wire logic bus_control_input_second_i,
    input wire logic bus_control_input_third_i,
    input wire logic address_strobe_pin_i,
    input wire logic data_bus_enable_input_n_i,
    input wire logic [host_bus_pkg::SHARED_W-1:0] shared_address_data_port_in_i,
    output logic [host_bus_pkg::DATA_W-1:0] shared_address_data_port_out_o,
    output logic shared_address_data_port_oe_o,
    input wire logic [host_bus_pkg::DATA_W-1:0] first_port_in_i,
    output logic [host_bus_pkg::DATA_W-1:0] first_port_out_o,
    output logic first_port_oe_o,
    output logic [host_bus_pkg::DATA_W-1:0] second_port_out_o,
    output logic second_port_oe_o,
    input wire logic [host_bus_pkg::UPPER_W-1:0] upper_address_i,
    input wire logic resource_sel_i,
    input wire logic [host_bus_pkg::DATA_W-1:0] mem_rdata_i,
    output logic [host_bus_pkg::FULL_W-1:0] mem_addr_o,
    output logic [host_bus_pkg::DATA_W-1:0] mem_wdata_o,
    output logic mem_rd_o,
    output logic mem_wr_o,
    output logic mem_fetch_o,
    output logic odd_byte_o,
    output logic logic_array_input_o,
    output logic third_input_free_o,
    output logic strobe_pin_free_o,
    output logic third_port_top_free_o,
    output logic first_port_low_free_o
);
    import host_bus_pkg::*;

    typedef enum logic [1:0] {st_idle, st_read, st_write} access_state_e;

    logic [SYNC_W-1:0] raw_pins;
    logic [SYNC_W-1:0] syn_pins;
    logic ctl0_s, ctl1_s, ctl2_s, strobe_s, bus_en_n_s;
    logic [SHARED_W-1:0] shared_s;
    logic [DATA_W-1:0] pa_s;
    logic [UPPER_W-1:0] upper_s;

    // All pins are asynchronous to ref_clk_i, so every one passes two flops
    assign raw_pins = {bus_control_input_first_i, bus_control_input_second_i, bus_control_input_third_i,
                       address_strobe_pin_i, data_bus_enable_input_n_i, shared_address_data_port_in_i,
                       first_port_in_i, upper_address_i};

    pin_sync2 #(.W(SYNC_W)) u_sync (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .d_i(raw_pins),
        .q_o(syn_pins)
    );

    assign {ctl0_s, ctl1_s, ctl2_s, strobe_s, bus_en_n_s, shared_s, pa_s, upper_s} = syn_pins;

    // Profile is caught once after reset release and then frozen
    logic [2:0] profile, next_profile;
    logic loaded, next_loaded;
    logic settled, next_settled;

    // Settled rises one edge after loading, once the synchroniser holds real pin levels
    always_comb
    begin
        next_profile = loaded ? profile : profile_i;
        next_loaded = 1'b1;
        next_settled = loaded;
    end

    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            profile <= PROF_RESET;
            loaded <= 1'b0;
            settled <= 1'b0;
        end
        else
        begin
            profile <= next_profile;
            loaded <= next_loaded;
            settled <= next_settled;
        end
    end

    // Profile decode of the control pins into read, write and fetch levels
    logic rd_act, wr_act, fetch, strobe_used, ctl2_used, bus_en_used, pa_low_used, ext_addr, nonmux;

    always_comb
    begin
        rd_act = 1'b0;
        wr_act = !ctl0_s;
        fetch = 1'b0;
        strobe_used = 1'b1;
        ctl2_used = 1'b0;
        bus_en_used = 1'b0;
        pa_low_used = 1'b0;
        ext_addr = 1'b0;
        nonmux = nonmux_i;
        case (profile)
            PROF_MUX_BASIC:
            begin
                rd_act = !ctl1_s || !ctl2_s;
                fetch = !ctl2_s;
                ctl2_used = 1'b1;
            end
            PROF_MUX_EXT_ADDR:
            begin
                rd_act = !ctl1_s || !ctl2_s;
                fetch = !ctl2_s;
                ctl2_used = 1'b1;
                pa_low_used = 1'b1;
                ext_addr = 1'b1;
            end
            PROF_SINGLE_READ:
            begin
                rd_act = !ctl1_s;
                fetch = 1'b1;
            end
            PROF_RW_LEVEL:
            begin
                rd_act = ctl1_s && ctl0_s;
                wr_act = ctl1_s && !ctl0_s;
            end
            PROF_RW_LEVEL_BUS_EN:
            begin
                rd_act = ctl1_s && ctl0_s && !bus_en_n_s;
                wr_act = ctl1_s && !ctl0_s && !bus_en_n_s;
                bus_en_used = 1'b1;
            end
            PROF_NO_STROBE:
            begin
                rd_act = !ctl1_s;
                strobe_used = 1'b0;
                nonmux = 1'b1;
            end
            PROF_DATA_STROBE:
            begin
                rd_act = !ctl1_s && ctl0_s;
                wr_act = !ctl1_s && !ctl0_s;
            end
            default:
            begin
                wr_act = 1'b0;
            end
        endcase
        // Synchroniser resets to 0, which reads as an active low strobe; no access until settled
        if (!settled)
        begin
            rd_act = 1'b0;
            wr_act = 1'b0;
        end
    end

    // Unused profile pins are handed to the logic array and general I/O
    assign third_input_free_o = !ctl2_used;
    assign logic_array_input_o = ctl2_used ? 1'b0 : ctl2_s;
    assign strobe_pin_free_o = !strobe_used || nonmux;
    assign third_port_top_free_o = !bus_en_used;
    assign first_port_low_free_o = !pa_low_used && !nonmux;

    // Transparent while strobe is high; the value at its fall is held until the next strobe
    logic [SHARED_W-1:0] latched, next_latched;

    always_comb
    begin
        next_latched = latched;
        if (strobe_s && strobe_used && !nonmux)
        begin
            next_latched = shared_s;
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            latched <= SHARED_RESET;
        end
        else
        begin
            latched <= next_latched;
        end
    end

    // Full address: upper bits from general port pins, extended profile adds live nibble
    logic [FULL_W-1:0] addr_full;

    always_comb
    begin
        if (nonmux)
        begin
            addr_full = {upper_s, shared_s};
        end
        else if (ext_addr)
        begin
            addr_full = {upper_s[EXT_UPPER_W-1:0], latched, pa_s[EXT_LOW_W-1:0]};
        end
        else
        begin
            addr_full = {upper_s, latched};
        end
    end

    // Access sequencer; address frozen for the length of the access
    access_state_e state, next_state;
    logic [FULL_W-1:0] next_mem_addr;
    logic [DATA_W-1:0] rd_data, next_rd_data, next_wdata;
    logic next_rd, next_wr, next_fetch;

    always_comb
    begin
        next_state = state;
        next_mem_addr = mem_addr_o;
        next_rd_data = rd_data;
        next_wdata = mem_wdata_o;
        next_rd = 1'b0;
        next_wr = 1'b0;
        next_fetch = mem_fetch_o;
        case (state)
            st_idle:
            begin
                next_mem_addr = addr_full;
                if (rd_act)
                begin
                    next_state = st_read;
                    next_rd = 1'b1;
                    next_fetch = fetch;
                end
                else if (wr_act)
                begin
                    next_state = st_write;
                    next_fetch = 1'b0;
                end
            end
            st_read:
            begin
                if (resource_sel_i)
                begin
                    next_rd_data = mem_rdata_i;
                end
                if (!rd_act)
                begin
                    next_state = st_idle;
                end
            end
            st_write:
            begin
                // Data is sampled while the strobe is held and committed at its end
                next_wdata = nonmux ? pa_s : shared_s[DATA_W-1:0];
                if (!wr_act)
                begin
                    next_state = st_idle;
                    next_wr = 1'b1;
                end
            end
            default:
            begin
                next_state = st_idle;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            state <= st_idle;
            mem_addr_o <= ADDR_RESET;
            rd_data <= DATA_RESET;
            mem_wdata_o <= DATA_RESET;
            mem_rd_o <= 1'b0;
            mem_wr_o <= 1'b0;
            mem_fetch_o <= 1'b0;
        end
        else
        begin
            state <= next_state;
            mem_addr_o <= next_mem_addr;
            rd_data <= next_rd_data;
            mem_wdata_o <= next_wdata;
            mem_rd_o <= next_rd;
            mem_wr_o <= next_wr;
            mem_fetch_o <= next_fetch;
        end
    end

    // Byte lane follows address bit 0 only; there is no byte-high-enable input at all
    assign odd_byte_o = mem_addr_o[0];

    // Pin drivers: data only on a selected read, else released; in mux mode the chosen latch port drives the address
    logic rd_drive;
    assign rd_drive = (state == st_read) && !mem_rd_o && resource_sel_i && rd_act; // Read data loaded, strobe still on
    assign shared_address_data_port_out_o = rd_data;
    assign shared_address_data_port_oe_o = rd_drive && !nonmux;
    assign first_port_out_o = nonmux ? rd_data : latched[DATA_W-1:0];
    assign first_port_oe_o = nonmux ? rd_drive : (latch_out_cfg_i == LATCH_OUT_FIRST);
    assign second_port_out_o = latched[SHARED_W-1:DATA_W];
    assign second_port_oe_o = !nonmux && (latch_out_cfg_i == LATCH_OUT_SECOND);

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    property p_rd_start;
        (state == st_idle) && rd_act |=> mem_rd_o && (state == st_read) ##1 !mem_rd_o;
    endproperty
    a_rd_start: assert property (p_rd_start) else $error("read strobe did not start one read");

    property p_wr_commit;
        (state == st_write) && !wr_act |=> mem_wr_o && (state == st_idle);
    endproperty
    a_wr_commit: assert property (p_wr_commit) else $error("write not committed at strobe end");

    property p_shared_address_data_port_drive;
        shared_address_data_port_oe_o |-> rd_act && resource_sel_i && (state == st_read) && !mem_rd_o && !nonmux;
    endproperty
    a_shared_address_data_port_drive: assert property (p_shared_address_data_port_drive) else $error("address/data port driven outside read");

    property p_pa_release;
        nonmux && (state != st_read) |-> !first_port_oe_o;
    endproperty
    a_pa_release: assert property (p_pa_release) else $error("first port driven while idle");

    property p_latch_hold;
        !strobe_s && strobe_used && !nonmux |=> $stable(latched);
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("latched address moved without strobe");

    property p_single_fetch;
        (profile == PROF_SINGLE_READ) && (state == st_idle) && rd_act |=> mem_fetch_o;
    endproperty
    a_single_fetch: assert property (p_single_fetch) else $error("single-read access not a fetch");

    property p_rnw_write;
        (profile == PROF_RW_LEVEL) && (state == st_idle) && ctl1_s && !ctl0_s |=> state == st_write;
    endproperty
    a_rnw_write: assert property (p_rnw_write) else $error("read-not-write low did not write");

    property p_ext_nibble;
        (profile == PROF_MUX_EXT_ADDR) && !nonmux && (state == st_idle) && rd_act
            |=> mem_addr_o[EXT_LOW_W-1:0] == $past(pa_s[EXT_LOW_W-1:0]);
    endproperty
    a_ext_nibble: assert property (p_ext_nibble) else $error("low nibble not from first port");

    property p_nonmux_addr;
        nonmux && (state == st_idle) && rd_act |=> mem_addr_o[SHARED_W-1:0] == $past(shared_s);
    endproperty
    a_nonmux_addr: assert property (p_nonmux_addr) else $error("non-mux address not taken live");

    property p_profile_frozen;
        loaded |=> $stable(profile);
    endproperty
    a_profile_frozen: assert property (p_profile_frozen) else $error("profile changed at run time");

    property p_no_early_access;
        !settled |=> !mem_rd_o && !mem_wr_o;
    endproperty
    a_no_early_access: assert property (p_no_early_access) else $error("access started before pins settled");

    c_read: cover property ((state == st_read) && resource_sel_i ##1 state == st_idle);
    c_write: cover property (mem_wr_o);
    c_nonmux_read: cover property (nonmux && first_port_oe_o);
endmodule

// ### logic/pin_sync2.sv
// Two-flop synchroniser for a vector of asynchronous pins
`timescale 1ns/1ps
module pin_sync2 #(
    parameter int W = 1
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta;
    logic [W-1:0] next_meta;
    logic [W-1:0] next_q;

    // First stage feeds only the second stage
    always_comb
    begin
        next_meta = d_i;
        next_q = meta;
    end

    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            meta <= '0;
            q_o <= '0;
        end
        else
        begin
            meta <= next_meta;
            q_o <= next_q;
        end
    end
endmodule

// ### tb/mcu_host_model.sv
// Host microcontroller model that drives the bus pins of the port
`timescale 1ns/1ps
module mcu_host_model
    import host_bus_pkg::*;
(
    input wire logic ref_clk_i,
    output logic ctl_first_o,
    output logic ctl_second_o,
    output logic ctl_third_o,
    output logic strobe_o,
    output logic bus_en_n_o,
    output logic [host_bus_pkg::SHARED_W-1:0] ad_o,
    output logic [host_bus_pkg::DATA_W-1:0] fp_o,
    output logic [host_bus_pkg::UPPER_W-1:0] up_o
);
    import host_bus_pkg::*;

    // Idle host: strobes inactive, lines at arbitrary values
    initial
    begin
        ctl_first_o = 1'b1;
        ctl_second_o = 1'b1;
        ctl_third_o = 1'b1;
        strobe_o = 1'b0;
        bus_en_n_o = 1'b1;
        ad_o = 16'h0000;
        fp_o = 8'h05;
        up_o = 8'h5c;
    end

    // Address phase; with a strobe profile the low lines are turned round afterwards so a stale address cannot pass
    task automatic addr_phase(input logic [2:0] prof, input logic [15:0] a);
        ad_o = a;
        if (prof != PROF_NO_STROBE)
        begin
            strobe_o = 1'b1;
            @(negedge ref_clk_i);
            strobe_o = 1'b0;
            @(negedge ref_clk_i);
            ad_o[7:0] = ~a[7:0];
        end
    endtask

    // Write data goes on the port that the profile uses for data
    task automatic put_data(input logic [2:0] prof, input logic [7:0] d);
        if (prof == PROF_NO_STROBE)
            fp_o = d;
        else
            ad_o[7:0] = d;
    endtask

    // Control pins for one access kind, on or off
    task automatic strobe(input logic [2:0] prof, input logic rd, input logic fetch, input logic on);
        case (prof)
            PROF_RW_LEVEL, PROF_RW_LEVEL_BUS_EN:
            begin
                ctl_first_o = rd;
                ctl_second_o = on;
                bus_en_n_o = !(on && prof == PROF_RW_LEVEL_BUS_EN);
            end
            PROF_DATA_STROBE:
            begin
                ctl_first_o = rd;
                ctl_second_o = !on;
            end
            default:
            begin
                ctl_first_o = !(on && !rd);
                ctl_second_o = !(on && rd && !fetch);
                ctl_third_o = !(on && rd && fetch);
            end
        endcase
        // A host releasing its data lines leaves them changing, not holding
        if (on && rd && prof == PROF_NO_STROBE)
            fp_o = ~fp_o;
    endtask
endmodule

// ### tb/mcu_parallel_bus_interface_tb_top.sv
// Self-checking bench for the host parallel bus port
`timescale 1ns/1ps
module mcu_parallel_bus_interface_tb_top;
    import host_bus_pkg::*;

    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [2:0] profile = PROF_MUX_BASIC;
    logic nonmux = 1'b0;
    logic [1:0] lcfg = LATCH_OUT_NONE;
    logic c0, c1, c2, ale, bus_en_n, ad_oe, fp_oe, sp_oe, mem_rd, mem_wr, mem_fetch, odd, la_in;
    logic third_free, strobe_free, top_free, fpl_free;
    logic [15:0] ad_o, ad_wire;
    logic [7:0] fp_o, fp_wire, up, ad_out, fp_out, sp_out, mem_wdata;
    logic [23:0] mem_addr;
    int bad_count = 0;
    int cmp_count = 0;

    always #2 clk = ~clk;

    // Pin levels from both parties; internal memory answers from the address
    assign ad_wire = {ad_o[15:8], ad_oe ? ad_out : ad_o[7:0]};
    assign fp_wire = fp_oe ? fp_out : fp_o;

    host_bus_port i_host_bus_port (.ref_clk_i(clk), .rst_i(rst), .profile_i(profile), .nonmux_i(nonmux),
        .latch_out_cfg_i(lcfg), .bus_control_input_first_i(c0), .bus_control_input_second_i(c1),
        .bus_control_input_third_i(c2), .address_strobe_pin_i(ale), .data_bus_enable_input_n_i(bus_en_n),
        .shared_address_data_port_in_i(ad_wire), .shared_address_data_port_out_o(ad_out),
        .shared_address_data_port_oe_o(ad_oe), .first_port_in_i(fp_wire), .first_port_out_o(fp_out),
        .first_port_oe_o(fp_oe), .second_port_out_o(sp_out), .second_port_oe_o(sp_oe), .upper_address_i(up),
        .resource_sel_i(mem_addr[15:12] != 4'hf), .mem_rdata_i(mem_addr[7:0] ^ 8'h3c), .mem_addr_o(mem_addr),
        .mem_wdata_o(mem_wdata), .mem_rd_o(mem_rd), .mem_wr_o(mem_wr), .mem_fetch_o(mem_fetch),
        .odd_byte_o(odd), .logic_array_input_o(la_in), .third_input_free_o(third_free),
        .strobe_pin_free_o(strobe_free), .third_port_top_free_o(top_free), .first_port_low_free_o(fpl_free));

    mcu_host_model i_mcu_host_model (.ref_clk_i(clk), .ctl_first_o(c0), .ctl_second_o(c1), .ctl_third_o(c2),
        .strobe_o(ale), .bus_en_n_o(bus_en_n), .ad_o(ad_o), .fp_o(fp_o), .up_o(up));

    task automatic stop_test();
        $display("Compares %0d, mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic check(input logic [23:0] got, input logic [23:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Bounded wait for a read or write pulse; a hang ends the run
    task automatic wait_pulse(input logic wr);
        int n;
        n = 0;
        while ((wr ? mem_wr : mem_rd) !== 1'b1 && n < 20)
        begin
            @(negedge clk);
            n++;
        end
        if ((wr ? mem_wr : mem_rd) !== 1'b1)
        begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
            stop_test();
        end
    endtask

    task automatic reset_dut(input logic [2:0] prof, input logic [1:0] cfg);
        @(negedge clk);
        rst = 1'b1;
        profile = prof;
        nonmux = (prof == PROF_NO_STROBE);
        lcfg = cfg;
        i_mcu_host_model.strobe(prof, 1'b1, 1'b0, 1'b0);
        repeat (5) @(negedge clk);
        rst = 1'b0;
        // No access may start while the pin synchroniser still holds its reset value
        repeat (3)
        begin
            @(negedge clk);
            check({mem_rd, mem_wr}, 2'b00);
        end
    endtask

    // One read: address, strobe, internal access, data on the bus, release
    task automatic do_read(input logic [2:0] p, input logic [15:0] a, input logic f, input logic [23:0] ea,
        input logic ef, input logic eoe);
        i_mcu_host_model.addr_phase(p, a);
        i_mcu_host_model.strobe(p, 1'b1, f, 1'b1);
        wait_pulse(1'b0);
        check(mem_addr, ea);
        check(mem_fetch, ef);
        check(odd, ea[0]);
        repeat (3) @(negedge clk);
        check(nonmux ? fp_oe : ad_oe, eoe);
        if (eoe)
            check(nonmux ? fp_out : ad_out, ea[7:0] ^ 8'h3c);
        i_mcu_host_model.strobe(p, 1'b1, f, 1'b0);
        repeat (6) @(negedge clk);
        check(nonmux ? fp_oe : ad_oe, 1'b0);
    endtask

    task automatic do_write(input logic [2:0] p, input logic [15:0] a, input logic [7:0] d, input logic [23:0] ea);
        i_mcu_host_model.addr_phase(p, a);
        @(negedge clk); // Turnround cycle, so the low lines change once per step
        i_mcu_host_model.put_data(p, d);
        i_mcu_host_model.strobe(p, 1'b0, 1'b0, 1'b1);
        repeat (4) @(negedge clk);
        i_mcu_host_model.strobe(p, 1'b0, 1'b0, 1'b0);
        wait_pulse(1'b1);
        check(mem_wdata, d);
        check(mem_addr, ea);
        repeat (2) @(negedge clk);
    endtask

    // Basic multiplexed profile; the profile input moves after reset and must not matter
    task automatic t_basic();
        reset_dut(PROF_MUX_BASIC, LATCH_OUT_NONE);
        profile = PROF_RW_LEVEL;
        do_read(PROF_MUX_BASIC, 16'h1235, 1'b0, 24'h5c1235, 1'b0, 1'b1);
        do_read(PROF_MUX_BASIC, 16'h2234, 1'b1, 24'h5c2234, 1'b1, 1'b1);
        do_read(PROF_MUX_BASIC, 16'hf011, 1'b0, 24'h5cf011, 1'b0, 1'b0);
        do_write(PROF_MUX_BASIC, 16'h3457, 8'ha5, 24'h5c3457);
        check({third_free, strobe_free, top_free, fpl_free}, 4'h3);
        $display("test basic done");
    endtask

    // Extended address profile: low nibble from the first port, top nibble from upper pins
    task automatic t_ext();
        reset_dut(PROF_MUX_EXT_ADDR, LATCH_OUT_NONE);
        do_read(PROF_MUX_EXT_ADDR, 16'h789a, 1'b0, 24'hc789a5, 1'b0, 1'b1);
        check(fpl_free, 1'b0);
        $display("test ext done");
    endtask

    // Single read input; third input is handed to the logic array
    task automatic t_single();
        reset_dut(PROF_SINGLE_READ, LATCH_OUT_NONE);
        do_read(PROF_SINGLE_READ, 16'h0102, 1'b0, 24'h5c0102, 1'b1, 1'b1);
        check(third_free, 1'b1);
        i_mcu_host_model.ctl_third_o = 1'b0;
        repeat (4) @(negedge clk);
        check(la_in, 1'b0);
        i_mcu_host_model.ctl_third_o = 1'b1;
        repeat (4) @(negedge clk);
        check(la_in, 1'b1);
        $display("test single done");
    endtask

    // Level read/write profiles, with and without data bus enable, and the data strobe one
    task automatic t_level();
        logic [2:0] profs [3] = '{PROF_RW_LEVEL, PROF_RW_LEVEL_BUS_EN, PROF_DATA_STROBE};
        foreach (profs[i])
        begin
            reset_dut(profs[i], LATCH_OUT_NONE);
            do_read(profs[i], 16'h4a61, 1'b0, 24'h5c4a61, 1'b0, 1'b1);
            do_write(profs[i], 16'h4b62, 8'h3e, 24'h5c4b62);
            check(top_free, profs[i] != PROF_RW_LEVEL_BUS_EN);
        end
        check(top_free, 1'b1);
        $display("test level done");
    endtask

    // No address strobe: live address, data on the first port, port idle when not accessed
    task automatic t_nomux();
        reset_dut(PROF_NO_STROBE, LATCH_OUT_NONE);
        check(fp_oe, 1'b0);
        do_read(PROF_NO_STROBE, 16'h4567, 1'b0, 24'h5c4567, 1'b0, 1'b1);
        do_write(PROF_NO_STROBE, 16'h5678, 8'hc3, 24'h5c5678);
        check(strobe_free, 1'b1);
        // Non-mux host on the basic strobe profile; the latched-address port must stay off
        reset_dut(PROF_MUX_BASIC, LATCH_OUT_SECOND);
        nonmux = 1'b1;
        do_read(PROF_NO_STROBE, 16'h6789, 1'b0, 24'h5c6789, 1'b0, 1'b1);
        do_write(PROF_NO_STROBE, 16'h789b, 8'h5a, 24'h5c789b);
        check(sp_oe, 1'b0);
        $display("test nomux done");
    endtask

    // Latched address shown on the first and then the second port
    task automatic t_latch();
        reset_dut(PROF_MUX_BASIC, LATCH_OUT_FIRST);
        do_read(PROF_MUX_BASIC, 16'h9abc, 1'b0, 24'h5c9abc, 1'b0, 1'b1);
        check({fp_oe, fp_out}, 9'h1bc);
        reset_dut(PROF_MUX_BASIC, LATCH_OUT_SECOND);
        do_read(PROF_MUX_BASIC, 16'h9abd, 1'b0, 24'h5c9abd, 1'b0, 1'b1);
        check({sp_oe, sp_out}, 9'h19a);
        $display("test latch done");
    endtask

    initial
    begin
        t_basic();
        t_ext();
        t_single();
        t_level();
        t_nomux();
        t_latch();
        stop_test();
    end
endmodule
